// file: iapr_top.v
// Operation
// - active register ignores all software writes
// - active bit reads one while interrupt active
// - bits 0-7 report port2/port3 wake inputs
// - bits 8-16 report serial, timer, usb sources
// - bits 17-19, 21-24 adc, watchdog, brownout, ports
// - reserved active bits read zero, writes ignored
// - four priorities per word, 32 levels each
// - fields at 7:3, 15:11, 23:19, 31:27
// - zero highest priority, 31 lowest
// - low three bits drop writes, read zero
// - words cover port0 wake inputs 0-11
`timescale 1ns/100ps
module iapr_top (
  input  wire        i_clk_sys,
  input  wire        i_rst_n,
  input  wire        i_ce,
  input  wire [31:0] i_addr,
  input  wire [31:0] i_wdata,
  input  wire        i_wr,
  input  wire        i_rd,
  output reg  [31:0] o_rdata,
  input  wire [3:0]  i_active_wake_p2_pin8,
  input  wire [3:0]  i_active_wake_p3_pin0,
  input  wire        i_active_i2c_flag,
  input  wire        i_active_timer16_first,
  input  wire        i_active_timer16_second,
  input  wire        i_active_timer32_first,
  input  wire        i_active_timer32_second,
  input  wire        i_active_sync_serial,
  input  wire        i_active_uart_flag,
  input  wire        i_active_usb_normal,
  input  wire        i_active_usb_fast,
  input  wire        i_active_adc_flag,
  input  wire        i_active_watchdog_flag,
  input  wire        i_active_brownout_flag,
  input  wire [3:0]  i_active_gpio_port,
  input  wire [11:0] i_wake_p0_req,
  output reg         o_req_valid,
  output reg  [3:0]  o_req_idx,
  output reg  [4:0]  o_req_prio,
  output wire        o_irq
);
  `include "iapr_map.vh"

  reg  [31:0] prio_word [0:2];
  reg  [31:0] irq_stat;
  reg  [31:0] irq_mask;
  reg  [11:0] pend_en;
  reg  [31:0] active_q;
  wire [31:0] active_now;
  wire [59:0] prios;
  wire        arb_valid;
  wire [3:0]  arb_idx;
  wire [4:0]  arb_prio;
  reg  [31:0] next_rdata;
  reg  [31:0] rise;
  integer     n;

  function [31:0] prio_wr;
    input [31:0] d;
    begin
      prio_wr = d & `IAPR_PRIO_MASK;
    end
  endfunction

  function is_prio;
    input [31:0] a;
    begin
      is_prio = (a == `IAPR_OFF_PRIO0) || (a == `IAPR_OFF_PRIO1) || (a == `IAPR_OFF_PRIO2);
    end
  endfunction

  // active word assembly
  assign active_now = {7'h00,
                       i_active_gpio_port[0], i_active_gpio_port[1],
                       i_active_gpio_port[2], i_active_gpio_port[3],
                       1'b0,
                       i_active_brownout_flag, i_active_watchdog_flag,
                       i_active_adc_flag,
                       i_active_usb_fast, i_active_usb_normal,
                       i_active_uart_flag, i_active_sync_serial,
                       i_active_timer32_second, i_active_timer32_first,
                       i_active_timer16_second, i_active_timer16_first,
                       i_active_i2c_flag,
                       i_active_wake_p3_pin0, i_active_wake_p2_pin8};

  // per-word field extraction: word 0 = inputs 0-3, word 1 = 4-7, word 2 = 8-11
  iapr_prio_field u_f0 (.i_word(prio_word[0]), .o_prios(prios[19:0]));
  iapr_prio_field u_f1 (.i_word(prio_word[1]), .o_prios(prios[39:20]));
  iapr_prio_field u_f2 (.i_word(prio_word[2]), .o_prios(prios[59:40]));

  iapr_arbiter u_arb (
    .i_req   (i_wake_p0_req & pend_en),
    .i_prios (prios),
    .o_valid (arb_valid),
    .o_idx   (arb_idx),
    .o_prio  (arb_prio)
  );

  always @* begin
    rise = active_now & ~active_q;
  end

  always @* begin
    next_rdata = 32'h00000000;
    case (i_addr)
      `IAPR_OFF_ACTIVE:   next_rdata = active_now & `IAPR_ACTIVE_MASK;
      `IAPR_OFF_PRIO0:    next_rdata = prio_word[0];
      `IAPR_OFF_PRIO1:    next_rdata = prio_word[1];
      `IAPR_OFF_PRIO2:    next_rdata = prio_word[2];
      `IAPR_OFF_IRQ_STAT: next_rdata = irq_stat;
      `IAPR_OFF_IRQ_MASK: next_rdata = irq_mask;
      `IAPR_OFF_PEND_EN:  next_rdata = {20'h00000, pend_en};
      `IAPR_OFF_WINNER:   next_rdata = {18'h00000, arb_valid, arb_prio, 4'h0, arb_idx};
      default:            next_rdata = 32'h00000000;
    endcase
  end

  always @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      for (n = 0; n < 3; n = n + 1) begin
        prio_word[n] <= `IAPR_PRIO_RESET;
      end
      irq_stat    <= 32'h00000000;
      irq_mask    <= 32'h00000000;
      pend_en     <= 12'h000;
      active_q    <= 32'h00000000;
      o_rdata     <= 32'h00000000;
      o_req_valid <= 1'b0;
      o_req_idx   <= 4'h0;
      o_req_prio  <= 5'h00;
    end else if (i_ce) begin
      active_q    <= active_now & `IAPR_ACTIVE_MASK;
      o_req_valid <= arb_valid;
      o_req_idx   <= arb_idx;
      o_req_prio  <= arb_prio;
      o_rdata     <= i_rd ? next_rdata : 32'h00000000;
      // write to the active word has no decode: writes are dropped
      if (i_wr && is_prio(i_addr)) begin
        prio_word[i_addr[3:2]] <= prio_wr(i_wdata);
      end
      if (i_wr && i_addr == `IAPR_OFF_IRQ_MASK) begin
        irq_mask <= i_wdata & `IAPR_ACTIVE_MASK;
      end
      if (i_wr && i_addr == `IAPR_OFF_PEND_EN) begin
        pend_en <= i_wdata[11:0];
      end
      // rising active edges set sticky bits; set wins over write-one-clear
      if (i_wr && i_addr == `IAPR_OFF_IRQ_STAT) begin
        irq_stat <= (irq_stat & ~i_wdata) | (rise & `IAPR_ACTIVE_MASK);
      end else begin
        irq_stat <= irq_stat | (rise & `IAPR_ACTIVE_MASK);
      end
    end
  end

  assign o_irq = |(irq_stat & irq_mask);
endmodule

// file: iapr_map.vh
`ifndef IAPR_MAP_VH
`define IAPR_MAP_VH
`define IAPR_ADDR_W         32
`define IAPR_OFF_ACTIVE     32'hE000E304
`define IAPR_OFF_PRIO0      32'hE000E400
`define IAPR_OFF_PRIO1      32'hE000E404
`define IAPR_OFF_PRIO2      32'hE000E408
`define IAPR_OFF_IRQ_STAT   32'hE000E500
`define IAPR_OFF_IRQ_MASK   32'hE000E504
`define IAPR_OFF_PEND_EN    32'hE000E508
`define IAPR_OFF_WINNER     32'hE000E50C
`define IAPR_ACTIVE_MASK    32'h01EFFFFF
`define IAPR_PRIO_MASK      32'hF8F8F8F8
`define IAPR_PRIO_RESET     32'h00000000
`define IAPR_PRIO_W         5
`define IAPR_PRIO_LSB       3
`define IAPR_FIELD_STRIDE   8
`define IAPR_NUM_PRIO_SRC   12
`define IAPR_IDX_W          4
`define IAPR_NUM_ACTIVE     25
`endif

// file: iapr_prio_field.v
`timescale 1ns/100ps
module iapr_prio_field (
  input  wire [31:0] i_word,
  output wire [19:0] o_prios
);
  `include "iapr_map.vh"
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : fld
      assign o_prios[g*5 +: 5] = i_word[g*`IAPR_FIELD_STRIDE + `IAPR_PRIO_LSB +: `IAPR_PRIO_W];
    end
  endgenerate
endmodule

// file: iapr_arbiter.v
`timescale 1ns/100ps
module iapr_arbiter (
  input  wire [11:0] i_req,
  input  wire [59:0] i_prios,
  output reg         o_valid,
  output reg  [3:0]  o_idx,
  output reg  [4:0]  o_prio
);
  integer k;
  always @* begin
    o_valid = 1'b0;
    o_idx   = 4'h0;
    o_prio  = 5'h1F;
    for (k = 0; k < 12; k = k + 1) begin
      // strict less-than keeps the lower number on a tie
      if (i_req[k] && (!o_valid || i_prios[k*5 +: 5] < o_prio)) begin
        o_valid = 1'b1;
        o_idx   = k[3:0];
        o_prio  = i_prios[k*5 +: 5];
      end
    end
  end
endmodule

// file: iapr_props.sv
`timescale 1ns/100ps
module iapr_props (
  input wire        i_clk_sys,
  input wire        i_rst_n,
  input wire        i_ce,
  input wire [31:0] i_addr,
  input wire        i_rd,
  input wire [31:0] o_rdata,
  input wire [11:0] i_wake_p0_req,
  input wire        o_req_valid,
  input wire [3:0]  o_req_idx,
  input wire        o_irq
);
  wire rd = i_rd && i_ce;
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);
  a_rdata_idle: assert property (!$past(rd) |-> o_rdata == 32'h0)
    else $error("read data outside read");
  a_prio_low_zero: assert property ($past(rd && i_addr[31:4] == 28'hE000E40 &&
    i_addr[3:0] inside {4'h0, 4'h4, 4'h8}) |-> (o_rdata & 32'h07070707) == 32'h0)
    else $error("priority low bits set");
  a_active_rsvd_zero: assert property ($past(rd && i_addr == 32'hE000E304)
    |-> o_rdata[31:25] == 7'h0 && !o_rdata[20]) else $error("reserved active bit set");
  a_unmapped_zero: assert property ($past(rd && i_addr[31:12] != 20'hE000E)
    |-> o_rdata == 32'h0) else $error("unmapped read not zero");
  a_reset_clear: assert property ($past(!i_rst_n)
    |-> o_rdata == 32'h0 && !o_req_valid && !o_irq) else $error("not clear after reset");
  a_req_none: assert property ($past(i_wake_p0_req == 12'h0) |-> !o_req_valid)
    else $error("winner without request");
  a_req_idx_pending: assert property (o_req_valid |-> o_req_idx < 4'hC &&
    |(($past(i_wake_p0_req) >> o_req_idx) & 12'h1)) else $error("winner not pending");
  a_winner_rsvd: assert property ($past(rd && i_addr == 32'hE000E50C)
    |-> o_rdata[31:14] == 18'h0 && o_rdata[7:4] == 4'h0) else $error("winner word bad");
endmodule
bind iapr_top iapr_props u_props (.i_clk_sys, .i_rst_n, .i_ce, .i_addr, .i_rd, .o_rdata,
  .i_wake_p0_req, .o_req_valid, .o_req_idx, .o_irq);

// file: iapr_src.sv
`timescale 1ns/100ps
module iapr_src (
  input  wire        i_clk_sys,
  input  wire [24:0] i_pat,
  output reg  [24:0] o_active
);
  initial o_active = 25'h0;
  // sources hold their request as a level
  always @(posedge i_clk_sys) begin
    o_active <= i_pat;
  end
endmodule

// file: irq_active_and_priority_regs_test.sv
`timescale 1ns/100ps
module irq_active_and_priority_regs_test;
  reg         clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, ce = 1'b1;
  reg  [31:0] addr = 32'h0, wdata = 32'h0;
  reg  [24:0] pat = 25'h0;
  reg  [11:0] req = 12'h0;
  wire [24:0] a;
  wire [31:0] rdata;
  wire        v, irq;
  wire [3:0]  idx;
  wire [4:0]  pr;
  integer     mismatches = 0, n_checks = 0, b;
  initial forever #5 clk = ~clk;
  iapr_src src (.i_clk_sys(clk), .i_pat(pat), .o_active(a));
  iapr_top uut (.i_clk_sys(clk), .i_rst_n(rst_n), .i_ce(ce), .i_addr(addr),
    .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_active_wake_p2_pin8(a[3:0]),
    .i_active_wake_p3_pin0(a[7:4]), .i_active_i2c_flag(a[8]), .i_active_timer16_first(a[9]),
    .i_active_timer16_second(a[10]), .i_active_timer32_first(a[11]),
    .i_active_timer32_second(a[12]), .i_active_sync_serial(a[13]),
    .i_active_uart_flag(a[14]), .i_active_usb_normal(a[15]), .i_active_usb_fast(a[16]),
    .i_active_adc_flag(a[17]), .i_active_watchdog_flag(a[18]),
    .i_active_brownout_flag(a[19]), .i_active_gpio_port({a[21], a[22], a[23], a[24]}),
    .i_wake_p0_req(req), .o_req_valid(v), .o_req_idx(idx), .o_req_prio(pr), .o_irq(irq));
  task chk(input [31:0] s, input [31:0] e);
    begin
      n_checks = n_checks + 1;
      if (s !== e) begin
        mismatches = mismatches + 1;
        $display("wrong value at %0t: seen %h expected %h", $time, s, e);
      end
    end
  endtask
  task wrt(input [31:0] ad, input [31:0] d);
    begin
      @(posedge clk);
      wr <= 1'b1;
      addr <= ad;
      wdata <= d;
      @(posedge clk);
      wr <= 1'b0;
    end
  endtask
  task rdc(input [31:0] ad, input [31:0] e);
    begin
      @(posedge clk);
      rd <= 1'b1;
      addr <= ad;
      @(posedge clk);
      rd <= 1'b0;
      @(negedge clk);
      chk(rdata, e);
    end
  endtask
  task win(input [11:0] r, input [31:0] e);
    begin
      @(posedge clk);
      req <= r;
      rdc(32'hE000E50C, e);
      chk({28'h0, idx}, e & 32'hF);
      chk({27'h0, pr}, (e >> 8) & 32'h1F);
      chk({31'h0, v}, (e >> 13) & 32'h1);
      @(posedge clk);
      req <= 12'h0;
    end
  endtask
  task end_of_test;
    begin
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0)
        $display("bench passed");
      else
        $display("bench failed");
      $finish;
    end
  endtask
  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    for (b = 0; b < 3; b = b + 1) begin
      rdc(32'hE000E400 + 4 * b, 32'h0);
      wrt(32'hE000E400 + 4 * b, 32'hFFFFFFFF);
      rdc(32'hE000E400 + 4 * b, 32'hF8F8F8F8);
      wrt(32'hE000E400 + 4 * b, 32'h8C4A2917);
      rdc(32'hE000E400 + 4 * b, 32'h88482810);
    end
    @(posedge clk);
    ce <= 1'b0;
    wrt(32'hE000E404, 32'h0);
    ce <= 1'b1;
    rdc(32'hE000E404, 32'h88482810);
    $display("priority words done");
    for (b = 0; b < 25; b = b + 1) begin
      @(posedge clk);
      pat <= 25'h1 << b;
      rdc(32'hE000E304, (32'h1 << b) & 32'h01EFFFFF);
    end
    @(posedge clk);
    pat <= 25'h1FFFFFF;
    wrt(32'hE000E304, 32'h0);
    rdc(32'hE000E304, 32'h01EFFFFF);
    $display("active word done");
    rdc(32'hE000E500, 32'h01EFFFFF);
    chk(irq, 32'h0);
    wrt(32'hE000E504, 32'h100);
    @(negedge clk);
    chk(irq, 32'h1);
    wrt(32'hE000E500, 32'h01EFFFFF);
    @(negedge clk);
    chk(irq, 32'h0);
    rdc(32'hE000E600, 32'h0);
    $display("interrupt done");
    wrt(32'hE000E508, 32'hFFF);
    wrt(32'hE000E400, 32'h002828F8);
    win(12'h006, 32'h2501);
    win(12'h00F, 32'h2003);
    win(12'h001, 32'h3F00);
    wrt(32'hE000E508, 32'hFF7);
    win(12'h00F, 32'h2501);
    wrt(32'hE000E508, 32'hFFF);
    wrt(32'hE000E400, 32'hFFFFFFFF);
    wrt(32'hE000E408, 32'h10F8F8F8);
    win(12'h801, 32'h220B);
    $display("arbiter done");
    end_of_test;
  end
endmodule
